// ### rtl/btd_pkg.sv
package btd_pkg;

	// ****************************************
	// Clock and sample timing
	// ****************************************
	localparam int SYS_CLK_HZ = 20000000;
	localparam int SAMPLE_HZ = 48000;
	// Sample tick divider, rounded down so ticks never run slow
	localparam int SAMPLE_DIV = SYS_CLK_HZ / SAMPLE_HZ;
	localparam int DEFAULT_BPM = 150;
	// Default beat in samples: 60 s per minute over the tempo
	localparam int DEFAULT_BEAT_SAMPLES = (SAMPLE_HZ * 60) / DEFAULT_BPM;
	localparam int BEAT_W = 24;
	localparam int LEN_W = 32;
	localparam int KNOB_MIN = 1;
	localparam int KNOB_MAX = 16;
	localparam int RANGE_ADD_BEATS = 16;
	localparam int EIGHTH_SHIFT = 3;
	// Voltage factor in Q5.8: 1.0 is 256, range 1/16 to 16
	localparam int CVF_W = 13;
	localparam int CVF_ONE = 256;
	localparam int CVF_FRAC = 8;
	localparam int LEVEL_FULL = 255;

	// ****************************************
	// Range switch and beat source
	// ****************************************
	typedef enum logic [2:0]
	{
		BTD_RANGE_DOWN = 3'h1,
		BTD_RANGE_MID = 3'h2,
		BTD_RANGE_UP = 3'h4
	} btd_range_t;

	typedef enum logic [3:0]
	{
		BTD_SRC_DEFAULT = 4'h1,
		BTD_SRC_TAP = 4'h2,
		BTD_SRC_JACK = 4'h4,
		BTD_SRC_BUS = 4'h8
	} btd_src_t;

endpackage

// ### rtl/btd_beat_if.sv
`timescale 1ns/1ps
interface btd_beat_if;
	import btd_pkg::*;
	logic sample_tick;
	logic beat_pulse;
	logic beat_change;
	logic [BEAT_W-1:0] beat_samples;
	modport src (output sample_tick, output beat_pulse, output beat_change, output beat_samples);
	modport snk (input sample_tick, input beat_pulse, input beat_change, input beat_samples);
endinterface

// ### rtl/btd_beat_gen.sv
`timescale 1ns/1ps
module btd_beat_gen
	import btd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic tap_evt,
	input wire logic jack_evt,
	input wire logic bus_evt,
	input wire logic bus_enable,
	btd_beat_if.src beat
);

	logic [15:0] div_r;
	logic [BEAT_W-1:0] meas_r;
	logic [BEAT_W-1:0] phase_r;
	logic tap_seen_r;
	logic jack_seen_r;
	logic bus_seen_r;
	logic sample_tick_r;
	logic beat_pulse_r;
	logic beat_change_r;
	logic [BEAT_W-1:0] beat_r;
	btd_src_t src_r;

	// ****************************************
	// Sample clock
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!nrst || div_r == 16'(SAMPLE_DIV - 1))
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
		sample_tick_r <= nrst && div_r == 16'(SAMPLE_DIV - 1);
	end

	// ****************************************
	// Interval measurement in whole samples
	// ****************************************
	// Events are latched and applied on the next sample edge, so every
	// measured interval is quantised to samples
	logic tap_p_r, jack_p_r, bus_p_r;
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			tap_p_r <= 1'b0;
			jack_p_r <= 1'b0;
			bus_p_r <= 1'b0;
		end
		else
		begin
			tap_p_r <= tap_evt || (tap_p_r && !sample_tick_r);
			jack_p_r <= jack_evt || (jack_p_r && !sample_tick_r);
			bus_p_r <= (bus_evt && bus_enable) || (bus_p_r && !sample_tick_r);
		end
	end

	logic any_evt;
	logic [BEAT_W-1:0] meas_next;
	assign any_evt = tap_p_r || jack_p_r || bus_p_r;
	assign meas_next = meas_r + BEAT_W'(1);

	always_ff @(posedge sys_clk)
	begin
		// Held until the next sample tick so the phase counters see it
		if (!nrst || sample_tick_r)
			beat_change_r <= 1'b0;
		if (!nrst)
		begin
			meas_r <= '0;
			tap_seen_r <= 1'b0;
			jack_seen_r <= 1'b0;
			bus_seen_r <= 1'b0;
			beat_r <= BEAT_W'(DEFAULT_BEAT_SAMPLES);
			src_r <= BTD_SRC_DEFAULT;
		end
		else if (sample_tick_r)
		begin
			if (meas_r != {BEAT_W{1'b1}})
				meas_r <= meas_next;
			if (any_evt)
				meas_r <= '0;
			// Each new edge re-measures; no averaging, drift is followed
			if (bus_p_r && bus_seen_r && meas_next != '0)
			begin
				beat_r <= meas_next;
				src_r <= BTD_SRC_BUS;
				beat_change_r <= 1'b1;
			end
			else if (jack_p_r && jack_seen_r && meas_next != '0)
			begin
				beat_r <= meas_next;
				src_r <= BTD_SRC_JACK;
				beat_change_r <= 1'b1;
			end
			else if (tap_p_r && tap_seen_r && meas_next != '0)
			begin
				beat_r <= meas_next;
				src_r <= BTD_SRC_TAP;
				beat_change_r <= 1'b1;
			end
			if (any_evt)
			begin
				tap_seen_r <= tap_p_r;
				jack_seen_r <= jack_p_r;
				bus_seen_r <= bus_p_r;
			end
		end
	end

	// ****************************************
	// Master beat pulse, on sample edges only
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		beat_pulse_r <= 1'b0;
		if (!nrst)
			phase_r <= '0;
		else if (sample_tick_r)
		begin
			if (beat_change_r || phase_r + BEAT_W'(1) >= beat_r)
			begin
				phase_r <= '0;
				beat_pulse_r <= 1'b1;
			end
			else
				phase_r <= phase_r + BEAT_W'(1);
		end
	end

	assign beat.sample_tick = sample_tick_r;
	assign beat.beat_pulse = beat_pulse_r;
	assign beat.beat_change = beat_change_r;
	assign beat.beat_samples = beat_r;

endmodule

// ### rtl/btd_channel.sv
`timescale 1ns/1ps
module btd_channel
	import btd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	btd_beat_if.snk beat,
	input wire logic [4:0] knob,
	input wire logic [2:0] range_sel,
	input wire logic [CVF_W-1:0] cv_factor,
	input wire logic freeze,
	input wire logic reverse_held,
	output logic [LEN_W-1:0] len,
	output logic loop_pulse,
	output logic trim_start,
	output logic trim_end,
	output logic [LEN_W-1:0] loop_start,
	output logic [LEN_W-1:0] loop_end
);

	logic [LEN_W-1:0] len_r;
	logic [LEN_W-1:0] phase_r;
	logic loop_pulse_r;
	logic trim_start_r;
	logic trim_end_r;
	logic [LEN_W-1:0] start_r;
	logic [LEN_W-1:0] end_r;

	// ****************************************
	// Length arithmetic, Q.8 beats
	// ****************************************
	logic [4:0] knob_c;
	logic [17:0] kv;
	logic [17:0] beats_q;
	logic [47:0] prod;
	logic [LEN_W-1:0] len_nxt;
	always_comb
	begin
		knob_c = (knob < 5'(KNOB_MIN)) ? 5'(KNOB_MIN) : ((knob > 5'(KNOB_MAX)) ? 5'(KNOB_MAX) : knob);
		kv = 18'(knob_c) * 18'(cv_factor);
		case (range_sel)
			BTD_RANGE_UP: beats_q = kv + 18'(RANGE_ADD_BEATS * CVF_ONE);
			BTD_RANGE_DOWN: beats_q = kv >> EIGHTH_SHIFT;
			default: beats_q = kv;
		endcase
		prod = 48'(beats_q) * 48'(beat.beat_samples);
		// Round to nearest sample, then floor at one
		len_nxt = LEN_W'((prod + 48'(CVF_ONE / 2)) >> CVF_FRAC);
		if (len_nxt == '0)
			len_nxt = LEN_W'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			len_r <= LEN_W'(DEFAULT_BEAT_SAMPLES);
		else
			len_r <= len_nxt;
	end

	// ****************************************
	// Loop clock and freeze trimming
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		loop_pulse_r <= 1'b0;
		if (!nrst)
			phase_r <= '0;
		else if (beat.sample_tick)
		begin
			// Restart with the beat so the ratio between channels holds
			if (beat.beat_change || phase_r + LEN_W'(1) >= len_r)
			begin
				phase_r <= '0;
				loop_pulse_r <= 1'b1;
			end
			else
				phase_r <= phase_r + LEN_W'(1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		trim_start_r <= 1'b0;
		trim_end_r <= 1'b0;
		if (!nrst)
		begin
			start_r <= '0;
			end_r <= LEN_W'(DEFAULT_BEAT_SAMPLES);
		end
		else if (!freeze)
		begin
			start_r <= '0;
			end_r <= len_r;
		end
		else if (len_nxt != len_r)
		begin
			if (reverse_held)
			begin
				end_r <= start_r + len_nxt;
				trim_end_r <= 1'b1;
			end
			else
			begin
				start_r <= end_r - len_nxt;
				trim_start_r <= 1'b1;
			end
		end
	end

	assign len = len_r;
	assign loop_pulse = loop_pulse_r;
	assign trim_start = trim_start_r;
	assign trim_end = trim_end_r;
	assign loop_start = start_r;
	assign loop_end = end_r;

endmodule

// ### rtl/btd_timebase.sv
`timescale 1ns/1ps
module btd_timebase
	import btd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic tap_btn,
	input wire logic ping_jack,
	input wire logic bus_clk,
	input wire logic bus_jumper,
	input wire logic [4:0] knob_a,
	input wire logic [4:0] knob_b,
	input wire logic [2:0] range_a,
	input wire logic [2:0] range_b,
	input wire logic [CVF_W-1:0] cvf_a,
	input wire logic [CVF_W-1:0] cvf_b,
	input wire logic freeze_a,
	input wire logic freeze_b,
	input wire logic rev_held_a,
	input wire logic rev_held_b,
	input wire logic [7:0] level_knob_a,
	input wire logic [7:0] level_knob_b,
	input wire logic signed [8:0] level_cv_a,
	input wire logic signed [8:0] level_cv_b,
	input wire logic audio_taper,
	input wire logic cv_to_mix,
	input wire logic [7:0] mix_knob_a,
	input wire logic [7:0] mix_knob_b,
	input wire logic signed [15:0] in_a,
	input wire logic signed [15:0] in_b,
	output logic main_clk,
	output logic loop_clk_a,
	output logic loop_clk_b,
	output logic [BEAT_W-1:0] beat_samples,
	output logic [LEN_W-1:0] len_a,
	output logic [LEN_W-1:0] len_b,
	output logic [LEN_W-1:0] start_a,
	output logic [LEN_W-1:0] start_b,
	output logic [LEN_W-1:0] end_a,
	output logic [LEN_W-1:0] end_b,
	output logic signed [15:0] rec_a,
	output logic signed [15:0] rec_b,
	output logic wr_en_a,
	output logic wr_en_b,
	output logic signed [15:0] dry_a,
	output logic signed [15:0] dry_b,
	output logic [7:0] mix_a,
	output logic [7:0] mix_b
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a rising edge counts while stage two is high and stage three is still low
	logic [2:0] tap_s_r, jack_s_r, bus_s_r;
	logic tap_evt, jack_evt, bus_evt;
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			tap_s_r <= 3'h0;
			jack_s_r <= 3'h0;
			bus_s_r <= 3'h0;
		end
		else
		begin
			tap_s_r <= {tap_s_r[1:0], tap_btn};
			jack_s_r <= {jack_s_r[1:0], ping_jack};
			bus_s_r <= {bus_s_r[1:0], bus_clk};
		end
	end
	assign tap_evt = tap_s_r[1] && !tap_s_r[2];
	assign jack_evt = jack_s_r[1] && !jack_s_r[2];
	assign bus_evt = bus_s_r[1] && !bus_s_r[2];

	// ****************************************
	// Shared beat and channels
	// ****************************************
	btd_beat_if bif ();

	btd_beat_gen u_beat (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.tap_evt(tap_evt),
		.jack_evt(jack_evt),
		.bus_evt(bus_evt),
		.bus_enable(bus_jumper),
		.beat(bif.src)
	);

	logic [LEN_W-1:0] len_a_w, len_b_w, st_a_w, st_b_w, en_a_w, en_b_w;
	logic lp_a_w, lp_b_w;

	btd_channel u_ch_a (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.beat(bif.snk),
		.knob(knob_a),
		.range_sel(range_a),
		.cv_factor(cvf_a),
		.freeze(freeze_a),
		.reverse_held(rev_held_a),
		.len(len_a_w),
		.loop_pulse(lp_a_w),
		.trim_start(),
		.trim_end(),
		.loop_start(st_a_w),
		.loop_end(en_a_w)
	);

	btd_channel u_ch_b (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.beat(bif.snk),
		.knob(knob_b),
		.range_sel(range_b),
		.cv_factor(cvf_b),
		.freeze(freeze_b),
		.reverse_held(rev_held_b),
		.len(len_b_w),
		.loop_pulse(lp_b_w),
		.trim_start(),
		.trim_end(),
		.loop_start(st_b_w),
		.loop_end(en_b_w)
	);

	// ****************************************
	// Record level
	// ****************************************
	function automatic logic [7:0] level_sum(input logic [7:0] k, input logic signed [8:0] cv, input logic en);
		logic [9:0] s;
		s = 10'(k);
		// Negative voltage ignored
		if (en && !cv[8])
			s = s + 10'(cv[7:0]);
		level_sum = (s > 10'(LEVEL_FULL)) ? 8'(LEVEL_FULL) : s[7:0];
	endfunction

	// Square law as a cheap audio taper; avoids a lookup table
	function automatic logic [7:0] taper(input logic [7:0] l, input logic aud);
		logic [15:0] sq;
		sq = 16'(l) * 16'(l);
		taper = aud ? sq[15:8] : l;
	endfunction

	function automatic logic signed [15:0] scale(input logic signed [15:0] x, input logic [7:0] g);
		logic signed [24:0] p;
		p = 25'(x) * $signed({1'b0, 8'(g)});
		// Divide by full scale so the gain is exactly linear in the setting
		scale = (g == 8'(LEVEL_FULL)) ? x : 16'(p / 25'sd255);
	endfunction

	logic [7:0] lvl_a, lvl_b;
	assign lvl_a = taper(level_sum(level_knob_a, level_cv_a, !cv_to_mix), audio_taper);
	assign lvl_b = taper(level_sum(level_knob_b, level_cv_b, !cv_to_mix), audio_taper);

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			main_clk <= 1'b0;
			loop_clk_a <= 1'b0;
			loop_clk_b <= 1'b0;
			beat_samples <= BEAT_W'(DEFAULT_BEAT_SAMPLES);
			len_a <= '0;
			len_b <= '0;
			start_a <= '0;
			start_b <= '0;
			end_a <= '0;
			end_b <= '0;
		end
		else
		begin
			main_clk <= bif.beat_pulse;
			loop_clk_a <= lp_a_w;
			loop_clk_b <= lp_b_w;
			beat_samples <= bif.beat_samples;
			len_a <= len_a_w;
			len_b <= len_b_w;
			start_a <= st_a_w;
			start_b <= st_b_w;
			end_a <= en_a_w;
			end_b <= en_b_w;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rec_a <= '0;
			rec_b <= '0;
			wr_en_a <= 1'b0;
			wr_en_b <= 1'b0;
			dry_a <= '0;
			dry_b <= '0;
			mix_a <= '0;
			mix_b <= '0;
		end
		else
		begin
			rec_a <= freeze_a ? 16'sh0000 : scale(in_a, lvl_a);
			rec_b <= freeze_b ? 16'sh0000 : scale(in_b, lvl_b);
			wr_en_a <= !freeze_a;
			wr_en_b <= !freeze_b;
			dry_a <= in_a;
			dry_b <= in_b;
			mix_a <= cv_to_mix ? level_sum(mix_knob_a, level_cv_a, 1'b1) : mix_knob_a;
			mix_b <= cv_to_mix ? level_sum(mix_knob_b, level_cv_b, 1'b1) : mix_knob_b;
		end
	end

endmodule

// ### test/btd_timebase_asserts.sv
`timescale 1ns/1ps
// ****
// Timebase checks
// ****
module btd_timebase_asserts
	import btd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] knob_a,
	input wire logic [2:0] range_a,
	input wire logic [CVF_W-1:0] cvf_a,
	input wire logic freeze_a,
	input wire logic signed [15:0] in_a,
	input wire logic main_clk,
	input wire logic loop_clk_a,
	input wire logic [BEAT_W-1:0] beat_samples,
	input wire logic [LEN_W-1:0] len_a,
	input wire logic [LEN_W-1:0] start_a,
	input wire logic [LEN_W-1:0] end_a,
	input wire logic signed [15:0] rec_a,
	input wire logic wr_en_a,
	input wire logic signed [15:0] dry_a
);
	int cnt_r;
	logic chg_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Interval since last beat pulse, skipped across beat changes
	always_ff @(posedge sys_clk)
		if (!nrst || main_clk)
			cnt_r <= 1;
		else
			cnt_r <= cnt_r + 1;
	always_ff @(posedge sys_clk)
		if (!nrst || $changed(beat_samples))
			chg_r <= 1'b1;
		else if (main_clk)
			chg_r <= 1'b0;
	property p_wr; $past(nrst) |-> wr_en_a == !$past(freeze_a); endproperty
	a_wr: assert property (p_wr) else $error("write enable wrong");
	property p_rec; freeze_a && $past(freeze_a) |-> rec_a == 16'h0000; endproperty
	a_rec: assert property (p_rec) else $error("record data while frozen");
	property p_dry; $past(nrst) |-> dry_a == $past(in_a); endproperty
	a_dry: assert property (p_dry) else $error("dry path altered");
	sequence s_mid;
		(range_a == BTD_RANGE_MID && cvf_a == CVF_ONE && knob_a inside {[1:16]} && $stable(knob_a)
			&& $stable(beat_samples))[*3];
	endsequence
	property p_mid; s_mid |-> len_a == knob_a * beat_samples; endproperty
	a_mid: assert property (p_mid) else $error("centre length wrong");
	property p_up;
		(range_a == BTD_RANGE_UP && cvf_a == CVF_ONE && knob_a inside {[1:16]} && $stable(knob_a)
			&& $stable(beat_samples))[*3] |-> len_a == (knob_a + RANGE_ADD_BEATS) * beat_samples;
	endproperty
	a_up: assert property (p_up) else $error("up length wrong");
	property p_free; (!freeze_a && $stable(len_a))[*3] |-> start_a == 0 && end_a == len_a; endproperty
	a_free: assert property (p_free) else $error("loop points not at length");
	property p_frz; (freeze_a && $stable(len_a))[*3] |-> end_a - start_a == len_a; endproperty
	a_frz: assert property (p_frz) else $error("frozen loop not at length");
	property p_mpulse; main_clk |=> !main_clk; endproperty
	a_mpulse: assert property (p_mpulse) else $error("main clock pulse too long");
	property p_lpulse; loop_clk_a |=> !loop_clk_a; endproperty
	a_lpulse: assert property (p_lpulse) else $error("loop clock pulse too long");
	property p_period; main_clk && !chg_r |-> cnt_r == $past(beat_samples) * SAMPLE_DIV; endproperty
	a_period: assert property (p_period) else $error("beat pulse off sample grid");
	c_period: cover property (main_clk && !chg_r);
	c_frz: cover property (freeze_a ##1 !wr_en_a);
	c_up: cover property (range_a == BTD_RANGE_UP && len_a != 0);
endmodule
bind btd_timebase btd_timebase_asserts u_chk (.sys_clk, .nrst, .knob_a, .range_a, .cvf_a, .freeze_a, .in_a,
	.main_clk, .loop_clk_a, .beat_samples, .len_a, .start_a, .end_a, .rec_a, .wr_en_a, .dry_a);

// ### test/btd_pulse_src.sv
`timescale 1ns/1ps
// ****
// Clock source or tapping hand
// ****
module btd_pulse_src
(
	input wire logic sys_clk,
	input wire logic run,
	input wire logic [31:0] period,
	output logic pulse
);
	int cnt_r = 0;
	// Rising edges exactly period clocks apart; period change takes effect mid-interval
	always @(posedge sys_clk)
		if (!run || cnt_r >= period - 1)
			cnt_r <= 0;
		else
			cnt_r <= cnt_r + 1;
	assign pulse = run && cnt_r < period / 2;
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb
	import btd_pkg::*;
;
	logic sys_clk = 0;
	logic nrst, bus_jumper, freeze_a, freeze_b, rev_held_a, rev_held_b, audio_taper, cv_to_mix;
	logic tap_btn, ping_jack, bus_clk, tap_run, ping_run, bus_run;
	logic main_clk, loop_clk_a, loop_clk_b, wr_en_a, wr_en_b;
	logic [4:0] knob_a, knob_b;
	logic [2:0] range_a, range_b;
	logic [CVF_W-1:0] cvf_a, cvf_b;
	logic [7:0] level_knob_a, level_knob_b, mix_knob_a, mix_knob_b, mix_a, mix_b;
	logic signed [8:0] level_cv_a, level_cv_b;
	logic signed [15:0] in_a, in_b, rec_a, rec_b, dry_a, dry_b;
	logic [BEAT_W-1:0] beat_samples;
	logic [LEN_W-1:0] len_a, len_b, start_a, start_b, end_a, end_b;
	int tap_per, ping_per, bus_per, errors, n_checks, bt;
	btd_pulse_src u_tap (.sys_clk, .run(tap_run), .period(tap_per), .pulse(tap_btn));
	btd_pulse_src u_ping (.sys_clk, .run(ping_run), .period(ping_per), .pulse(ping_jack));
	btd_pulse_src u_bus (.sys_clk, .run(bus_run), .period(bus_per), .pulse(bus_clk));
	btd_timebase DUT (.sys_clk, .nrst, .tap_btn, .ping_jack, .bus_clk, .bus_jumper, .knob_a, .knob_b,
		.range_a, .range_b, .cvf_a, .cvf_b, .freeze_a, .freeze_b, .rev_held_a, .rev_held_b, .level_knob_a,
		.level_knob_b, .level_cv_a, .level_cv_b, .audio_taper, .cv_to_mix, .mix_knob_a, .mix_knob_b, .in_a,
		.in_b, .main_clk, .loop_clk_a, .loop_clk_b, .beat_samples, .len_a, .len_b, .start_a, .start_b,
		.end_a, .end_b, .rec_a, .rec_b, .wr_en_a, .wr_en_b, .dry_a, .dry_b, .mix_a, .mix_b);
	initial
		forever #25 sys_clk = ~sys_clk;
	task end_sim;
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task chk_val(input string nm, input logic [LEN_W-1:0] e, input logic [LEN_W-1:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task chk_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Rounded to nearest sample; unknown switch codes read as centre
	function automatic int exp_len(input int k, input logic [2:0] r, input int c);
		if (r == BTD_RANGE_UP)
			return ((k * c + RANGE_ADD_BEATS * CVF_ONE) * bt + CVF_ONE / 2) / CVF_ONE;
		if (r == BTD_RANGE_DOWN)
			return (k * c * bt + (CVF_ONE << EIGHTH_SHIFT) / 2) / (CVF_ONE << EIGHTH_SHIFT);
		return (k * c * bt + CVF_ONE / 2) / CVF_ONE;
	endfunction
	task len_chk(input int k, input logic [2:0] r, input int c);
		knob_a = k;
		range_a = r;
		cvf_a = c;
		cyc(4);
		chk_val("len_a", exp_len(k, r, c), len_a);
	endtask
	task tap(input int s);
		tap_per = s * SAMPLE_DIV;
		tap_run = 1;
		cyc(tap_per + 100);
		tap_run = 0;
		cyc(3 * SAMPLE_DIV);
	endtask
	task lvl(input logic [7:0] k, input logic signed [8:0] cv, input logic t, input logic m,
		input logic signed [15:0] e);
		level_knob_a = k;
		level_cv_a = cv;
		audio_taper = t;
		cv_to_mix = m;
		cyc(3);
		chk_val("rec_a", e, rec_a);
		chk_val("dry_a", in_a, dry_a);
	endtask
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		end_sim;
	end
	initial
	begin
		{nrst, bus_jumper, freeze_a, freeze_b, rev_held_a, rev_held_b, audio_taper, cv_to_mix} = 8'h00;
		{tap_run, ping_run, bus_run, errors, n_checks} = 0;
		{tap_per, ping_per, bus_per} = {32'h1, 32'h1, 32'h1};
		{knob_a, knob_b, range_a, range_b} = {5'h05, 5'h0A, BTD_RANGE_MID, BTD_RANGE_MID};
		{cvf_a, cvf_b, level_cv_a, level_cv_b} = {13'h0100, 13'h0100, 9'h000, 9'h000};
		{level_knob_a, level_knob_b, mix_knob_a, mix_knob_b} = {8'hFF, 8'h80, 8'h40, 8'h40};
		{in_a, in_b} = {16'h639C, 16'h0100};
		cyc(10);
		nrst = 1;
		bt = DEFAULT_BEAT_SAMPLES;
		cyc(3);
		chk_val("beat", bt, beat_samples);
		len_chk(5, BTD_RANGE_MID, CVF_ONE);
		tap(10);
		bt = 10;
		chk_val("beat", bt, beat_samples);
		chk_val("len_b", exp_len(10, BTD_RANGE_MID, CVF_ONE), len_b);
		len_chk(5, BTD_RANGE_UP, CVF_ONE);
		len_chk(5, BTD_RANGE_DOWN, CVF_ONE);
		len_chk(4, BTD_RANGE_DOWN, CVF_ONE);
		len_chk(5, BTD_RANGE_MID, 13'h0200);
		len_chk(1, BTD_RANGE_MID, 13'h1000);
		len_chk(16, BTD_RANGE_MID, 13'h0010);
		len_chk(16, 3'h0, CVF_ONE);
		len_chk(5, BTD_RANGE_MID, CVF_ONE);
		freeze_a = 1;
		cyc(3);
		chk_bit("wr_en_a", 1'b0, wr_en_a);
		chk_val("rec_a", 32'h0, rec_a);
		len_chk(3, BTD_RANGE_MID, CVF_ONE);
		chk_val("start_a", 32'h14, start_a);
		chk_val("end_a", 32'h32, end_a);
		rev_held_a = 1;
		len_chk(4, BTD_RANGE_MID, CVF_ONE);
		chk_val("start_a", 32'h14, start_a);
		chk_val("end_a", 32'h3C, end_a);
		{rev_held_a, freeze_a} = 2'b00;
		cyc(3);
		chk_bit("wr_en_a", 1'b1, wr_en_a);
		chk_val("start_a", 32'h0, start_a);
		lvl(8'hC8, 9'h064, 1'b0, 1'b0, in_a);
		lvl(8'h00, 9'h1CE, 1'b0, 1'b0, 16'h0000);
		lvl(8'h00, 9'h0FF, 1'b0, 1'b1, 16'h0000);
		lvl(8'h33, 9'h000, 1'b0, 1'b0, 16'h13EC);
		audio_taper = 1;
		cyc(3);
		chk_bit("rec_a_taper", 1'b1, rec_a < 16'sh13EC);
		ping_per = 12 * SAMPLE_DIV;
		ping_run = 1;
		cyc(3 * ping_per);
		chk_val("beat", 32'hC, beat_samples);
		ping_per = 13 * SAMPLE_DIV;
		cyc(3 * ping_per);
		chk_val("beat", 32'hD, beat_samples);
		ping_run = 0;
		bus_per = 7 * SAMPLE_DIV;
		bus_run = 1;
		cyc(3 * bus_per);
		chk_val("beat", 32'hD, beat_samples);
		bus_jumper = 1;
		cyc(3 * bus_per);
		bt = 7;
		chk_val("beat", bt, beat_samples);
		chk_val("len_b", exp_len(10, BTD_RANGE_MID, CVF_ONE), len_b);
		bus_run = 0;
		end_sim;
	end
endmodule
